// >>> tmr8w_pkg.sv
// package: register map, field layout, modes and state record of the 8-bit waveform timer
package tmr8w_pkg;
    localparam logic [1:0] ADDR_CTRL    = 2'h0;
    localparam logic [1:0] ADDR_COUNT   = 2'h1;
    localparam logic [1:0] ADDR_COMPARE = 2'h2;
    localparam logic [1:0] ADDR_AUX     = 2'h3;

    localparam int BIT_FOC      = 7;
    localparam int BIT_MODE_LO  = 6;
    localparam int BIT_COM_HI   = 5;
    localparam int BIT_COM_LO   = 4;
    localparam int BIT_MODE_HI  = 3;
    localparam int BIT_CS_HI    = 2;
    localparam int BIT_ASYNC    = 0;
    localparam int BIT_OVF      = 1;
    localparam int BIT_CMF      = 2;

    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX       = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM    = 8'h00;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PHASE  = 2'h1;
    localparam logic [1:0] MODE_CTC    = 2'h2;
    localparam logic [1:0] MODE_FAST   = 2'h3;

    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_MASK_1    = 10'h000;
    localparam logic [PRE_W-1:0] PRE_MASK_8    = 10'h007;
    localparam logic [PRE_W-1:0] PRE_MASK_32   = 10'h01F;
    localparam logic [PRE_W-1:0] PRE_MASK_64   = 10'h03F;
    localparam logic [PRE_W-1:0] PRE_MASK_128  = 10'h07F;
    localparam logic [PRE_W-1:0] PRE_MASK_256  = 10'h0FF;
    localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;

    typedef struct packed {
        logic [7:0]       ctrl;
        logic [7:0]       cnt;
        logic [7:0]       ocr;
        logic [7:0]       ocr_buf;
        logic             down;
        logic             oc;
        logic             ovf;
        logic             cmf;
        logic             block;
        logic [PRE_W-1:0] pre;
        logic             async_sel;
        logic [2:0]       sync;
        logic             osc_lvl;
        logic             osc_prev;
        logic [7:0]       rdata;
    } tmr8w_state_t;
endpackage

// >>> tmr8w_top.sv
// module: 8-bit timer with compare channel, waveform output and prescaler
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R01: sync: tick enables clock; async: oscillator edges
// R02: forced compare works only in non-PWM modes
// R03: software writes force bit zero in PWM
// R04: forced compare applies current output action now
// R05: forced compare sets no flag, no clear
// R06: force bit always reads zero
// R07: mode field selects normal, phase, CLEAR_ON_MATCH_MODE, fast
// R08: compare buffering and overflow point per mode
// R09: output mode nonzero overrides port pin
// R10: non-PWM: disconnect, toggle, clear, set
// R11: fast PWM: clear/set at match, inverse TOP
// R12: phase PWM: up match one way, down other
// R13: compare at TOP with high bit ignored; the code acts at TOP only when the output mode high bit is set
// R14: clock select stop, direct, divided prescaler
// R15: counter directly readable and writable
// R16: counter write blocks next compare match
// R17: compare register continuously matched with counter
// R18: CLEAR_ON_MATCH_MODE compare below count wraps via 0xFF
// R19: fast PWM counts up, wraps to bottom
// R20: phase PWM up, turn at MAX without holding, down
// R21: flag and CLEAR_ON_MATCH_MODE clear on next tick
module tmr8w_top (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // oscillator pin for asynchronous operation
    input  wire logic       osc_pin,
    // port pin shared with the compare output
    input  wire logic       port_data,
    input  wire logic       port_dir,
    output logic            pin_out,
    output logic            pin_oe,
    // status levels
    output logic            overflow_flag,
    output logic            compare_match_flag
);
    tmr8w_pkg::tmr8w_state_t q, n;
    logic [1:0]                  mode;
    logic [1:0]                  com;
    logic                        pwm;
    logic                        src;
    logic                        tick;
    logic                        match;
    logic                        at_top;
    logic                        override;
    logic [tmr8w_pkg::PRE_W-1:0] mask;

    // output action; inv flips the meaning of the clear/set encodings
    function automatic logic oc_act(input logic [1:0] c, input logic cur,
                                    input logic tgl, input logic inv);
        oc_act = c[1] ? (c[0] ^ inv) : ((c[0] & tgl) ? ~cur : cur);
    endfunction

    function automatic logic is_pwm(input logic [1:0] m);
        is_pwm = (m == tmr8w_pkg::MODE_PHASE) || (m == tmr8w_pkg::MODE_FAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        mode     = {q.ctrl[tmr8w_pkg::BIT_MODE_HI], q.ctrl[tmr8w_pkg::BIT_MODE_LO]}; // [R07]
        com      = q.ctrl[tmr8w_pkg::BIT_COM_HI:tmr8w_pkg::BIT_COM_LO];
        pwm      = is_pwm(mode);
        override = (com != 2'h0);
        unique case (q.ctrl[tmr8w_pkg::BIT_CS_HI:0]) // [R14]
            3'h2:    mask = tmr8w_pkg::PRE_MASK_8;
            3'h3:    mask = tmr8w_pkg::PRE_MASK_32;
            3'h4:    mask = tmr8w_pkg::PRE_MASK_64;
            3'h5:    mask = tmr8w_pkg::PRE_MASK_128;
            3'h6:    mask = tmr8w_pkg::PRE_MASK_256;
            3'h7:    mask = tmr8w_pkg::PRE_MASK_1024;
            default: mask = tmr8w_pkg::PRE_MASK_1;
        endcase
        // async source: one step per settled rising edge of the oscillator pin
        src    = q.async_sel ? (q.osc_lvl & ~q.osc_prev) : 1'b1; // [R01]
        tick   = src && (q.ctrl[tmr8w_pkg::BIT_CS_HI:0] != 3'h0)
                 && ((q.pre & mask) == mask); // [R14]
        match  = (q.cnt == q.ocr) && !q.block; // [R16] [R17]
        at_top = (q.cnt == tmr8w_pkg::CNT_MAX);

        n       = q;
        n.rdata = 8'h00;
        // three-stage sampler; level accepted once stages two and three agree
        n.sync  = {q.sync[1:0], osc_pin};
        if (q.sync[1] == q.sync[2]) begin
            n.osc_lvl = q.sync[2];
        end
        n.osc_prev = q.osc_lvl;
        if (src) begin
            n.pre = q.pre + 10'h001;
        end

        // write one clears; applied before the tick so a same-cycle set wins
        if (reg_wr && reg_addr == tmr8w_pkg::ADDR_AUX) begin
            n.ovf = q.ovf & ~reg_wdata[tmr8w_pkg::BIT_OVF];
            n.cmf = q.cmf & ~reg_wdata[tmr8w_pkg::BIT_CMF];
        end

        if (tick) begin
            n.block = 1'b0;
            unique case (mode)
                tmr8w_pkg::MODE_NORMAL, tmr8w_pkg::MODE_CTC: begin
                    // CLEAR_ON_MATCH_MODE with compare below count runs on through 0xFF
                    if (match && mode == tmr8w_pkg::MODE_CTC) begin
                        n.cnt = tmr8w_pkg::CNT_BOTTOM; // [R21] [R18]
                    end else begin
                        n.cnt = q.cnt + 8'h01;
                    end
                    if (at_top) begin
                        n.ovf = 1'b1; // [R08]
                    end
                    if (match) begin
                        n.cmf = 1'b1; // [R21]
                        n.oc  = oc_act(com, q.oc, 1'b1, 1'b0); // [R10]
                    end
                end
                tmr8w_pkg::MODE_FAST: begin
                    n.cnt = q.cnt + 8'h01; // [R19]
                    if (match) begin
                        n.cmf = 1'b1;
                        n.oc  = oc_act(com, q.oc, 1'b0, 1'b0); // [R11]
                    end
                    if (at_top) begin
                        n.ovf = 1'b1; // [R08]
                        n.ocr = q.ocr_buf;
                        n.oc  = oc_act(com, q.oc, 1'b0, 1'b1); // [R11] [R13]
                    end
                end
                tmr8w_pkg::MODE_PHASE: begin
                    if (!q.down && at_top) begin
                        n.down = 1'b1;
                        n.cnt  = q.cnt - 8'h01; // [R20]
                    end else if (q.down && q.cnt == tmr8w_pkg::CNT_BOTTOM) begin
                        n.down = 1'b0;
                        n.cnt  = q.cnt + 8'h01;
                    end else begin
                        n.cnt = q.down ? q.cnt - 8'h01 : q.cnt + 8'h01;
                    end
                    if (q.cnt == tmr8w_pkg::CNT_BOTTOM) begin
                        n.ovf = 1'b1; // [R08]
                    end
                    if (match) begin
                        n.cmf = 1'b1;
                    end
                    // compare at TOP with high bit set: skip the match, act at TOP
                    if (at_top && q.ocr == tmr8w_pkg::CNT_MAX && com[1]) begin
                        n.oc = oc_act(com, q.oc, 1'b0, 1'b1); // [R13]
                    end else if (match) begin
                        n.oc = oc_act(com, q.oc, 1'b0, q.down); // [R12]
                    end
                    if (at_top) begin
                        n.ocr = q.ocr_buf; // [R08]
                    end
                end
                default: n.cnt = q.cnt;
            endcase
        end

        if (reg_wr) begin
            unique case (reg_addr)
                tmr8w_pkg::ADDR_CTRL: begin
                    n.ctrl = {1'b0, reg_wdata[6:0]};
                    // strobe: uses the output mode being written, no flag, no clear
                    if (reg_wdata[tmr8w_pkg::BIT_FOC]
                        && !is_pwm({reg_wdata[tmr8w_pkg::BIT_MODE_HI],
                                    reg_wdata[tmr8w_pkg::BIT_MODE_LO]})) begin
                        n.oc = oc_act(reg_wdata[tmr8w_pkg::BIT_COM_HI:tmr8w_pkg::BIT_COM_LO],
                                      n.oc, 1'b1, 1'b0); // [R02] [R04] [R05]
                    end
                end
                tmr8w_pkg::ADDR_COUNT: begin
                    n.cnt   = reg_wdata; // [R15]
                    n.block = 1'b1; // [R16]
                end
                tmr8w_pkg::ADDR_COMPARE: begin
                    n.ocr_buf = reg_wdata;
                    if (!pwm) begin
                        n.ocr = reg_wdata; // [R08]
                    end
                end
                tmr8w_pkg::ADDR_AUX: begin
                    n.async_sel = reg_wdata[tmr8w_pkg::BIT_ASYNC]; // [R01]
                end
                default: n.ctrl = n.ctrl;
            endcase
        end

        if (reg_rd) begin
            unique case (reg_addr)
                tmr8w_pkg::ADDR_CTRL:    n.rdata = {1'b0, q.ctrl[6:0]}; // [R06]
                tmr8w_pkg::ADDR_COUNT:   n.rdata = q.cnt; // [R15]
                tmr8w_pkg::ADDR_COMPARE: n.rdata = q.ocr_buf;
                tmr8w_pkg::ADDR_AUX:     n.rdata = {5'h00, q.cmf, q.ovf, q.async_sel};
                default:                 n.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (srst) begin
            q         <= '0;
            q.ctrl    <= tmr8w_pkg::CTRL_RESET;
            q.cnt     <= tmr8w_pkg::COUNT_RESET;
            q.ocr     <= tmr8w_pkg::COMPARE_RESET;
            q.ocr_buf <= tmr8w_pkg::COMPARE_RESET;
        end else begin
            q <= n;
        end
    end

    assign reg_rdata          = q.rdata;
    assign pin_out            = override ? q.oc : port_data; // [R09]
    assign pin_oe             = port_dir; // [R09]
    assign overflow_flag      = q.ovf;
    assign compare_match_flag = q.cmf;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_foc_no_flag;
        (reg_wr && reg_addr == tmr8w_pkg::ADDR_CTRL && reg_wdata[7] && !tick && !q.cmf)
            |=> !q.cmf;
    endproperty
    a_foc_no_flag: assert property (p_foc_no_flag) else $error("forced compare set flag"); // [R05]

    property p_foc_pwm_inert;
        (reg_wr && reg_addr == tmr8w_pkg::ADDR_CTRL && reg_wdata[7] && !tick
         && is_pwm({reg_wdata[3], reg_wdata[6]})) |=> $stable(q.oc);
    endproperty
    a_foc_pwm_inert: assert property (p_foc_pwm_inert) else $error("force acted in PWM"); // [R02]

    property p_foc_read_zero;
        (reg_rd && reg_addr == tmr8w_pkg::ADDR_CTRL) |=> !reg_rdata[7];
    endproperty
    a_foc_read_zero: assert property (p_foc_read_zero) else $error("force bit read one"); // [R06]

    property p_block;
        (q.block && tick) |=> !$rose(q.cmf);
    endproperty
    a_block: assert property (p_block) else $error("match not blocked"); // [R16]

    property p_stopped;
        (q.ctrl[2:0] == 3'h0) |-> !tick;
    endproperty
    a_stopped: assert property (p_stopped) else $error("tick while stopped"); // [R14]

    property p_fast_wrap;
        (tick && !reg_wr && mode == tmr8w_pkg::MODE_FAST && at_top)
            |=> (q.cnt == 8'h00) && q.ovf;
    endproperty
    a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap wrong"); // [R19]

    property p_phase_turn;
        (tick && !reg_wr && mode == tmr8w_pkg::MODE_PHASE && !q.down && at_top)
            |=> (q.cnt == 8'hFE) && q.down;
    endproperty
    a_phase_turn: assert property (p_phase_turn) else $error("phase turn wrong"); // [R20]

    property p_ctc_clear;
        (tick && !reg_wr && mode == tmr8w_pkg::MODE_CTC && match)
            |=> (q.cnt == 8'h00) && q.cmf;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("CLEAR_ON_MATCH_MODE clear wrong"); // [R21]

    // an async tick needs two agreeing high pin samples one clock before
    property p_async_src;
        (q.async_sel && tick) |-> $past(q.sync[1]) && $past(q.sync[2]);
    endproperty
    a_async_src: assert property (p_async_src) else $error("async tick w/o edge"); // [R01]

    property p_pin_override;
        override |-> (pin_out == q.oc) && (pin_oe == port_dir);
    endproperty
    a_pin_override: assert property (p_pin_override) else $error("pin not overridden"); // [R09]

    property p_ovf_set_wins;
        (tick && at_top && mode != tmr8w_pkg::MODE_PHASE) |=> q.ovf;
    endproperty
    a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("overflow set lost"); // [R08]

    property p_ovf_clear;
        (reg_wr && reg_addr == tmr8w_pkg::ADDR_AUX && reg_wdata[tmr8w_pkg::BIT_OVF]
         && !(tick && (at_top || q.cnt == tmr8w_pkg::CNT_BOTTOM))) |=> !q.ovf;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared"); // [R08]

    property p_cmf_clear;
        (reg_wr && reg_addr == tmr8w_pkg::ADDR_AUX && reg_wdata[tmr8w_pkg::BIT_CMF]
         && !(tick && q.cnt == q.ocr)) |=> !q.cmf;
    endproperty
    a_cmf_clear: assert property (p_cmf_clear) else $error("match flag not cleared"); // [R17]

    c_overflow: cover property ($rose(q.ovf));
    c_match:    cover property ($rose(q.cmf));
    c_phase:    cover property (mode == tmr8w_pkg::MODE_PHASE && $rose(q.down));
    c_foc:      cover property (reg_wr && reg_addr == 2'h0 && reg_wdata[7]);
    c_async:    cover property (q.async_sel && tick);
endmodule

`default_nettype wire

// >>> test_tmr8w_top.sv
// testbench: register-level checks of the 8-bit waveform timer
`timescale 1ns/10ps
`default_nettype none
module test_tmr8w_top;
    logic       clock, srst, reg_wr, reg_rd, osc_pin, port_data, port_dir;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v1, v2;
    logic       pin_out, pin_oe, overflow_flag, compare_match_flag;
    int         error_cnt, num_checks, cycles, hi;
    int         divs[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] fc[6] = '{8'h98, 8'h98, 8'hB8, 8'hA8, 8'hB8, 8'h08};
    logic       pe[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    tmr8w_top dut_u (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_pin(osc_pin),
        .port_data(port_data), .port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe),
        .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // two count samples exactly d clocks apart
    task automatic span(input int d);
        rd(tmr8w_pkg::ADDR_COUNT, v1);
        repeat (d - 2) @(posedge clock);
        rd(tmr8w_pkg::ADDR_COUNT, v2);
    endtask
    task automatic duty(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clock);
            #1;
            hi += int'(pin_out);
        end
    endtask
    function automatic logic [7:0] tri_step(input logic [7:0] v, input int k);
        int s;
        s = int'(v) + k;
        return (s <= 255) ? 8'(s) : 8'(510 - s);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        clock = 0; srst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        osc_pin = 0; port_data = 0; port_dir = 1;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd(2'(a), v1);
            chk("reset value", v1, 16'h0000);
        end
        wr(tmr8w_pkg::ADDR_CTRL, 8'h88);
        rd(tmr8w_pkg::ADDR_CTRL, v1);
        chk("control readback", v1, 16'h0008);
        wr(tmr8w_pkg::ADDR_COUNT, 8'h5A);
        rd(tmr8w_pkg::ADDR_COUNT, v1);
        chk("count readback", v1, 16'h005A);
        wr(tmr8w_pkg::ADDR_COMPARE, 8'hC3);
        rd(tmr8w_pkg::ADDR_COMPARE, v1);
        chk("compare readback", v1, 16'h00C3);
        // forced compares on a stopped clear-on-match timer
        for (int i = 0; i < 6; i++) begin
            wr(tmr8w_pkg::ADDR_CTRL, fc[i]);
            #1;
            chk("forced pin", pin_out, pe[i]);
            chk("forced flag", compare_match_flag, 1'b0);
        end
        rd(tmr8w_pkg::ADDR_COUNT, v1);
        chk("count after force", v1, 16'h005A);
        @(posedge clock);
        port_data <= 1'b1;
        port_dir  <= 1'b0;
        @(posedge clock);
        #1;
        chk("port passthrough", pin_out, 1'b1);
        chk("driver enable", pin_oe, 1'b0);
        @(posedge clock);
        port_dir  <= 1'b1;
        port_data <= 1'b0;
        wr(tmr8w_pkg::ADDR_CTRL, 8'h78);
        wr(tmr8w_pkg::ADDR_CTRL, 8'hE8);
        #1;
        chk("force ignored in pwm", pin_out, 1'b1);
        // prescaler: two ticks per window of twice the divisor, none when stopped
        wr(tmr8w_pkg::ADDR_AUX, 8'h06);
        for (int cs = 0; cs < 8; cs++) begin
            wr(tmr8w_pkg::ADDR_CTRL, 8'(cs));
            span(2 * divs[cs]);
            chk("ticks per window", 8'(v2 - v1), (cs == 0) ? 16'h0 : 16'h2);
        end
        // asynchronous source: only oscillator edges count
        wr(tmr8w_pkg::ADDR_CTRL, 8'h01);
        wr(tmr8w_pkg::ADDR_AUX, 8'h01);
        span(20);
        chk("async idle", 8'(v2 - v1), 16'h0);
        rd(tmr8w_pkg::ADDR_COUNT, v1);
        repeat (5) begin
            osc_pin <= 1'b1;
            repeat (8) @(posedge clock);
            osc_pin <= 1'b0;
            repeat (8) @(posedge clock);
        end
        rd(tmr8w_pkg::ADDR_COUNT, v2);
        chk("async ticks", 8'(v2 - v1), 16'h5);
        // clear-on-match period and missed match
        wr(tmr8w_pkg::ADDR_AUX, 8'h06);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h08);
        wr(tmr8w_pkg::ADDR_COUNT, 8'h00);
        wr(tmr8w_pkg::ADDR_COMPARE, 8'h05);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h09);
        repeat (4) begin
            rd(tmr8w_pkg::ADDR_COUNT, v1);
            chk("count bound", 8'(v1 <= 8'h05), 16'h1);
        end
        span(6);
        chk("match period", v2, v1);
        chk("match flag", compare_match_flag, 1'b1);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h08);
        wr(tmr8w_pkg::ADDR_COUNT, 8'h0A);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h09);
        span(20);
        chk("count past compare", 8'(v2 - v1), 16'h14);
        // counter write blocks the next match
        wr(tmr8w_pkg::ADDR_CTRL, 8'h00);
        wr(tmr8w_pkg::ADDR_COMPARE, 8'h20);
        wr(tmr8w_pkg::ADDR_AUX, 8'h06);
        wr(tmr8w_pkg::ADDR_COUNT, 8'h20);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h01);
        repeat (10) @(posedge clock);
        chk("blocked match", compare_match_flag, 1'b0);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h00);
        wr(tmr8w_pkg::ADDR_COUNT, 8'h1E);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h01);
        repeat (10) @(posedge clock);
        chk("normal match", compare_match_flag, 1'b1);
        wr(tmr8w_pkg::ADDR_AUX, 8'h06);
        wr(tmr8w_pkg::ADDR_COUNT, 8'hFA);
        repeat (10) @(posedge clock);
        chk("overflow at max", overflow_flag, 1'b1);
        wr(tmr8w_pkg::ADDR_AUX, 8'h06);
        rd(tmr8w_pkg::ADDR_AUX, v1);
        chk("flags cleared", v1, 16'h0000);
        // count shapes of the two pwm modes
        wr(tmr8w_pkg::ADDR_CTRL, 8'h48);
        wr(tmr8w_pkg::ADDR_COUNT, 8'hF0);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h49);
        span(20);
        chk("single slope", v2, 8'(v1 + 8'h14));
        wr(tmr8w_pkg::ADDR_CTRL, 8'h40);
        wr(tmr8w_pkg::ADDR_COUNT, 8'hF0);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h41);
        span(20);
        chk("dual slope", v2, tri_step(v1, 20));
        wr(tmr8w_pkg::ADDR_AUX, 8'h06);
        repeat (300) @(posedge clock);
        chk("overflow at bottom", overflow_flag, 1'b1);
        // duty cycles, compare loaded at top
        wr(tmr8w_pkg::ADDR_CTRL, 8'h48);
        wr(tmr8w_pkg::ADDR_COMPARE, 8'h80);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h69);
        repeat (600) @(posedge clock);
        duty(256);
        chk("fast duty", 16'(hi), 16'h0081);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h79);
        repeat (300) @(posedge clock);
        duty(256);
        chk("fast inverted duty", 16'(hi), 16'h007F);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h69);
        wr(tmr8w_pkg::ADDR_COMPARE, 8'hFF);
        repeat (600) @(posedge clock);
        duty(256);
        chk("compare at top", 16'(hi), 16'h0100);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h40);
        wr(tmr8w_pkg::ADDR_COMPARE, 8'h40);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h61);
        repeat (600) @(posedge clock);
        duty(510);
        chk("phase duty", 16'(hi), 16'h0080);
        wr(tmr8w_pkg::ADDR_CTRL, 8'h71);
        repeat (600) @(posedge clock);
        duty(510);
        chk("phase inverted duty", 16'(hi), 16'h017E);
        end_of_test();
    end
endmodule
`default_nettype wire
